// *** spdif_status_user_buffers.sv ***
// Purpose: Status, channel status and user-bit register group of a digital audio receiver/transmitter
// Assumes: The control port decodes the serial protocol into single-cycle byte read and write strobes
// Notes:   Read data is registered one cycle after the read strobe
//          The receive status buffer is kept twice so a host read never competes with a transmit fetch;
//          both copies take the same writes and never differ
//          User-bit buffers have no reset; software writes a byte before it trusts it
//          Writes to read-only or disabled locations are dropped without any error indication
//
// Functional notes
// - Bit 3 flags compressed CD preamble detected
// - Bit 2 flags nonaudio frame data received
// - Bit 1 flags channel A subframe nonaudio
// - Bit 0 flags channel B subframe nonaudio
// - Receive status buffer is 24 bytes, 0x20-0x37
// - Received professional bit sits at 0x20 bit 0
// - Receive status buffer read-only unless autobuffering
// - Transmit status buffer is 24 bytes, 0x38-0x4F
// - Transmitted professional bit from 0x38 bit 0
// - Autobuffering disables transmit buffer, sends received status
// - Receive user pointer register at 0x50
// - Read of 0x51 returns pointed receive user byte
// - Receive user buffer writable only when autobuffering
// - Transmit user pointer register at 0x52
// - Write of 0x53 stores pointed transmit byte
// - User autobuffering disables transmit user buffer
// - Bit 1 of 0x54 flags subcode check fail
// - Check fail flag sticky, no interrupt
// - Reading 0x54 clears check fail flag
// - Bit 0 of 0x54 flags subcode loaded
`timescale 1ns/1ps
`include "spdif_regs_defines.svh"
module spdif_status_user_buffers
  import spdif_regs_pkg::*;
(
  input  wire logic         core_clk,
  input  wire logic         reset,
  // Host register port
  input  wire logic         reg_write,
  input  wire logic         reg_read,
  input  wire reg_addr_type reg_addr,
  input  wire byte_type     reg_wdata,
  output byte_type          reg_rdata,
  // Autobuffer modes
  input  wire logic         cs_autobuffer,
  input  wire logic         user_autobuffer,
  // Receiver detection events
  input  wire logic         compressed_cd_detect,
  input  wire logic         nonaudio_frame_detect,
  input  wire logic         subframe_a_detect,
  input  wire logic         subframe_b_detect,
  input  wire logic         subcode_check_fail_event,
  input  wire logic         subcode_loaded_event,
  // Receiver channel status load
  input  wire logic         rx_cs_write,
  input  wire logic [4:0]   rx_cs_index,
  input  wire byte_type     rx_cs_data,
  // Receiver user bits load
  input  wire logic         rx_user_write,
  input  wire byte_type     rx_user_index,
  input  wire byte_type     rx_user_data,
  // Transmitter channel status and user bits fetch; received professional bit
  input  wire logic [4:0]   tx_cs_index,
  output byte_type          tx_cs_data,
  output logic              tx_professional_use_bit,
  input  wire byte_type     tx_user_index,
  output byte_type          tx_user_data,
  output logic              rx_professional_use_bit
);
  // ==========================================================
  // Address decode
  logic       in_rx_cs;
  logic       in_tx_cs;
  logic [4:0] rx_cs_host_index;
  logic [4:0] tx_cs_host_index;
  logic       rx_cs_host_write;
  logic       tx_cs_host_write;
  logic       rx_user_host_write;
  logic       tx_user_host_write;
  logic       rx_pointer_write;
  logic       tx_pointer_write;

  always_comb begin
    in_rx_cs = (reg_addr >= `RX_CS_FIRST_ADDR) && (reg_addr <= `RX_CS_LAST_ADDR);
    in_tx_cs = (reg_addr >= `TX_CS_FIRST_ADDR) && (reg_addr <= `TX_CS_LAST_ADDR);
    rx_cs_host_index = 5'(reg_addr - `RX_CS_FIRST_ADDR);
    tx_cs_host_index = 5'(reg_addr - `TX_CS_FIRST_ADDR);
  end

  // Writes to read-only or disabled locations fall through and are lost
  always_comb begin
    rx_cs_host_write   = 1'b0;
    tx_cs_host_write   = 1'b0;
    rx_user_host_write = 1'b0;
    tx_user_host_write = 1'b0;
    rx_pointer_write   = 1'b0;
    tx_pointer_write   = 1'b0;
    if (reg_write) begin
      if (in_rx_cs) begin
        rx_cs_host_write = cs_autobuffer;
      end else if (in_tx_cs) begin
        tx_cs_host_write = !cs_autobuffer;
      end else if (reg_addr == `RX_USER_POINTER_ADDR) begin
        rx_pointer_write = 1'b1;
      end else if (reg_addr == `RX_USER_BYTE_ADDR) begin
        rx_user_host_write = user_autobuffer;
      end else if (reg_addr == `TX_USER_POINTER_ADDR) begin
        tx_pointer_write = 1'b1;
      end else if (reg_addr == `TX_USER_BYTE_ADDR) begin
        tx_user_host_write = !user_autobuffer;
      end
    end
  end

  // ==========================================================
  // Nonaudio stream type, live detection flags
  // Flags follow the detectors one cycle late and keep no history
  logic [3:0] nonaudio_reg;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      nonaudio_reg <= 4'h0;
    end else begin
      nonaudio_reg[`COMPRESSED_CD_BIT]  <= compressed_cd_detect;
      nonaudio_reg[`NONAUDIO_FRAME_BIT] <= nonaudio_frame_detect;
      nonaudio_reg[`SUBFRAME_A_BIT]     <= subframe_a_detect;
      nonaudio_reg[`SUBFRAME_B_BIT]     <= subframe_b_detect;
    end
  end

  // ==========================================================
  // User-bit pointers
  // Pointers hold across accesses; software moves them for every byte
  byte_type rx_user_pointer_reg;
  byte_type tx_user_pointer_reg;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      rx_user_pointer_reg <= `POINTER_RESET;
    end else if (rx_pointer_write) begin
      rx_user_pointer_reg <= reg_wdata;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      tx_user_pointer_reg <= `POINTER_RESET;
    end else if (tx_pointer_write) begin
      tx_user_pointer_reg <= reg_wdata;
    end
  end

  // ==========================================================
  // Q subcode status
  logic subcode_check_fail_reg;
  logic subcode_loaded_reg;
  logic status_read;

  assign status_read = reg_read && (reg_addr == `SUBCODE_STATUS_ADDR);

  // A new failure in the read cycle survives the clear; no interrupt path exists
  always_ff @(posedge core_clk) begin
    if (reset) begin
      subcode_check_fail_reg <= 1'b0;
    end else if (subcode_check_fail_event) begin
      subcode_check_fail_reg <= 1'b1;
    end else if (status_read) begin
      subcode_check_fail_reg <= 1'b0;
    end
  end

  // Loaded flag is sticky; only reset clears it
  always_ff @(posedge core_clk) begin
    if (reset) begin
      subcode_loaded_reg <= 1'b0;
    end else if (subcode_loaded_event) begin
      subcode_loaded_reg <= 1'b1;
    end
  end

  // ==========================================================
  // Buffers
  byte_type rx_cs_read;
  byte_type tx_cs_read;
  byte_type rx_cs_tx_read;
  byte_type tx_cs_own;
  byte_type rx_user_host_read;
  byte_type rx_user_hw_read;
  byte_type tx_user_own;
  logic     rx_pro;
  logic     tx_pro;
  // Both receive copies take every write; the second one serves only the transmitter fetch

  cs_buffer u_rx_cs (
    .core_clk   (core_clk),
    .reset      (reset),
    .host_write (rx_cs_host_write),
    .host_index (rx_cs_host_index),
    .host_data  (reg_wdata),
    .hw_write   (rx_cs_write),
    .hw_index   (rx_cs_index),
    .hw_data    (rx_cs_data),
    .read_index (rx_cs_host_index),
    .read_data  (rx_cs_read),
    .pro_bit    (rx_pro)
  );

  cs_buffer u_rx_cs_tx (
    .core_clk   (core_clk),
    .reset      (reset),
    .host_write (rx_cs_host_write),
    .host_index (rx_cs_host_index),
    .host_data  (reg_wdata),
    .hw_write   (rx_cs_write),
    .hw_index   (rx_cs_index),
    .hw_data    (rx_cs_data),
    .read_index (tx_cs_index),
    .read_data  (rx_cs_tx_read),
    .pro_bit    ()
  );

  cs_buffer u_tx_cs (
    .core_clk   (core_clk),
    .reset      (reset),
    .host_write (tx_cs_host_write),
    .host_index (tx_cs_host_index),
    .host_data  (reg_wdata),
    .hw_write   (1'b0),
    .hw_index   (5'h00),
    .hw_data    (`BYTE_RESET),
    .read_index (tx_cs_index),
    .read_data  (tx_cs_own),
    .pro_bit    (tx_pro)
  );

  cs_buffer u_tx_cs_host (
    .core_clk   (core_clk),
    .reset      (reset),
    .host_write (tx_cs_host_write),
    .host_index (tx_cs_host_index),
    .host_data  (reg_wdata),
    .hw_write   (1'b0),
    .hw_index   (5'h00),
    .hw_data    (`BYTE_RESET),
    .read_index (tx_cs_host_index),
    .read_data  (tx_cs_read),
    .pro_bit    ()
  );

  user_buffer u_rx_user (
    .core_clk        (core_clk),
    .host_write      (rx_user_host_write),
    .host_index      (rx_user_pointer_reg),
    .host_data       (reg_wdata),
    .hw_write        (rx_user_write),
    .hw_index        (rx_user_index),
    .hw_data         (rx_user_data),
    .host_read_index (rx_user_pointer_reg),
    .host_read_data  (rx_user_host_read),
    .hw_read_index   (tx_user_index),
    .hw_read_data    (rx_user_hw_read)
  );

  user_buffer u_tx_user (
    .core_clk        (core_clk),
    .host_write      (tx_user_host_write),
    .host_index      (tx_user_pointer_reg),
    .host_data       (reg_wdata),
    .hw_write        (1'b0),
    .hw_index        (8'h00),
    .hw_data         (8'h00),
    .host_read_index (tx_user_pointer_reg),
    .host_read_data  (),
    .hw_read_index   (tx_user_index),
    .hw_read_data    (tx_user_own)
  );

  // ==========================================================
  // Transmit side outputs
  // Registered so every fetch sees exactly one cycle of latency
  always_ff @(posedge core_clk) begin
    if (reset) begin
      tx_cs_data <= `BYTE_RESET;
    end else begin
      tx_cs_data <= cs_autobuffer ? rx_cs_tx_read : tx_cs_own;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      tx_professional_use_bit <= 1'b0;
    end else begin
      tx_professional_use_bit <= cs_autobuffer ? rx_pro : tx_pro;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      rx_professional_use_bit <= 1'b0;
    end else begin
      rx_professional_use_bit <= rx_pro;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      tx_user_data <= `BYTE_RESET;
    end else begin
      tx_user_data <= user_autobuffer ? rx_user_hw_read : tx_user_own;
    end
  end

  // ==========================================================
  // Read mux, registered; reserved bits and unmapped addresses read zero
  byte_type rdata_next;

  always_comb begin
    rdata_next = `BYTE_RESET;
    if (reg_addr == `NONAUDIO_TYPE_ADDR) begin
      rdata_next = {4'h0, nonaudio_reg};
    end else if (in_rx_cs) begin
      rdata_next = rx_cs_read;
    end else if (in_tx_cs) begin
      rdata_next = tx_cs_read;
    end else if (reg_addr == `RX_USER_POINTER_ADDR) begin
      rdata_next = rx_user_pointer_reg;
    end else if (reg_addr == `RX_USER_BYTE_ADDR) begin
      rdata_next = rx_user_host_read;
    end else if (reg_addr == `TX_USER_POINTER_ADDR) begin
      rdata_next = tx_user_pointer_reg;
    end else if (reg_addr == `TX_USER_BYTE_ADDR) begin
      rdata_next = `BYTE_RESET;
    end else if (reg_addr == `SUBCODE_STATUS_ADDR) begin
      rdata_next = {6'h00, subcode_check_fail_reg, subcode_loaded_reg};
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      reg_rdata <= `BYTE_RESET;
    end else if (reg_read) begin
      reg_rdata <= rdata_next;
    end
  end
endmodule // spdif_status_user_buffers

// *** spdif_regs_defines.svh ***
// Purpose: Register offsets, field positions and sizes for the status and user-bit register group
// Assumes: Byte-wide register port with 7-bit register addresses
// Notes:   Definitions only
`ifndef SPDIF_REGS_DEFINES_SVH
`define SPDIF_REGS_DEFINES_SVH

// ==========================================================
// Register offsets
`define NONAUDIO_TYPE_ADDR    7'h1F
`define RX_CS_FIRST_ADDR      7'h20
`define RX_CS_LAST_ADDR       7'h37
`define TX_CS_FIRST_ADDR      7'h38
`define TX_CS_LAST_ADDR       7'h4F
`define RX_USER_POINTER_ADDR  7'h50
`define RX_USER_BYTE_ADDR     7'h51
`define TX_USER_POINTER_ADDR  7'h52
`define TX_USER_BYTE_ADDR     7'h53
`define SUBCODE_STATUS_ADDR   7'h54

// ==========================================================
// Field positions
`define COMPRESSED_CD_BIT     3
`define NONAUDIO_FRAME_BIT    2
`define SUBFRAME_A_BIT        1
`define SUBFRAME_B_BIT        0
`define CHECK_FAIL_BIT        1
`define LOADED_BIT            0
`define PRO_BIT               0

// ==========================================================
// Sizes and reset values
`define CS_BYTES              24
`define USER_BYTES            256
`define POINTER_RESET         8'h00
`define BYTE_RESET            8'h00

`endif

// *** spdif_regs_pkg.sv ***
// Purpose: Shared types for the status and user-bit register group
// Assumes: Used together with spdif_regs_defines.svh
// Notes:   Types only
package spdif_regs_pkg;
  typedef logic [7:0] byte_type;
  typedef logic [6:0] reg_addr_type;
endpackage

// *** cs_buffer.sv ***
// Purpose: 24-byte channel status buffer with a host port and a hardware load port
// Assumes: Host and hardware writes are steered by the parent
// Notes:   Hardware load wins over a host write to the same byte in the same cycle
`timescale 1ns/1ps
`include "spdif_regs_defines.svh"
module cs_buffer
  import spdif_regs_pkg::*;
(
  input  wire logic     core_clk,
  input  wire logic     reset,
  input  wire logic     host_write,
  input  wire logic [4:0] host_index,
  input  wire byte_type host_data,
  input  wire logic     hw_write,
  input  wire logic [4:0] hw_index,
  input  wire byte_type hw_data,
  input  wire logic [4:0] read_index,
  output byte_type      read_data,
  output logic          pro_bit
);
  byte_type mem_reg [`CS_BYTES];

  // ==========================================================
  // Storage, one generate entry per byte
  genvar i;
  generate
    for (i = 0; i < `CS_BYTES; i++) begin : g_byte
      always_ff @(posedge core_clk) begin
        if (reset) begin
          mem_reg[i] <= `BYTE_RESET;
        end else if (hw_write && hw_index == 5'(i)) begin
          mem_reg[i] <= hw_data;
        end else if (host_write && host_index == 5'(i)) begin
          mem_reg[i] <= host_data;
        end
      end
    end
  endgenerate

  assign read_data = (read_index < 5'(`CS_BYTES)) ? mem_reg[read_index] : `BYTE_RESET;
  assign pro_bit   = mem_reg[0][`PRO_BIT];
endmodule // cs_buffer

// *** user_buffer.sv ***
// Purpose: 256-byte user-bit buffer with a host port and a hardware port
// Assumes: Parent decides which port may write
// Notes:   Hardware write wins over a host write in the same cycle
`timescale 1ns/1ps
`include "spdif_regs_defines.svh"
module user_buffer
  import spdif_regs_pkg::*;
(
  input  wire logic     core_clk,
  input  wire logic     host_write,
  input  wire byte_type host_index,
  input  wire byte_type host_data,
  input  wire logic     hw_write,
  input  wire byte_type hw_index,
  input  wire byte_type hw_data,
  input  wire byte_type host_read_index,
  output byte_type      host_read_data,
  input  wire byte_type hw_read_index,
  output byte_type      hw_read_data
);
  // No reset: contents are data, not control
  byte_type mem_reg [`USER_BYTES];

  always_ff @(posedge core_clk) begin
    if (hw_write) begin
      mem_reg[hw_index] <= hw_data;
    end else if (host_write) begin
      mem_reg[host_index] <= host_data;
    end
  end

  assign host_read_data = mem_reg[host_read_index];
  assign hw_read_data   = mem_reg[hw_read_index];
endmodule // user_buffer

// *** spdif_regs_checker.sv ***
// Purpose: Port assertions for the status and user-bit register group
// Assumes: Bound to spdif_status_user_buffers
// Notes:   Watches design input and output ports only
`timescale 1ns/1ps
module spdif_regs_checker
  import spdif_regs_pkg::*;
(
  input wire logic         core_clk,
  input wire logic         reset,
  input wire logic         reg_read,
  input wire reg_addr_type reg_addr,
  input wire byte_type     reg_rdata,
  input wire logic         cs_autobuffer,
  input wire logic         compressed_cd_detect,
  input wire logic         nonaudio_frame_detect,
  input wire logic         subframe_a_detect,
  input wire logic         subframe_b_detect,
  input wire logic         subcode_check_fail_event,
  input wire logic         subcode_loaded_event,
  input wire logic         rx_cs_write,
  input wire logic [4:0]   rx_cs_index,
  input wire byte_type     rx_cs_data,
  input wire logic         tx_professional_use_bit,
  input wire logic         rx_professional_use_bit
);
  logic [3:0] det;
  logic       rd54;
  logic       rxw0;
  logic       ev;
  assign det  = {compressed_cd_detect, nonaudio_frame_detect, subframe_a_detect, subframe_b_detect};
  assign rd54 = reg_read && reg_addr == 7'h54;
  assign rxw0 = rx_cs_write && rx_cs_index == 5'h00;
  assign ev   = subcode_check_fail_event;
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  // ==========================================================
  // Register port
  a_flags_track: assert property (
    reg_read && reg_addr == 7'h1F && $stable(det) && !$past(reset) |=> reg_rdata == {4'h0, $past(det)})
    else $error("nonaudio flags differ from detect inputs");
  a_status_reserved: assert property (rd54 |=> reg_rdata[7:2] == 6'h00)
    else $error("status reserved bits not zero");
  a_fail_sets: assert property (ev ##1 !rd54 ##1 rd54 |=> reg_rdata[1])
    else $error("check fail flag not set");
  a_fail_clears: assert property (rd54 && !ev ##1 !ev ##1 rd54 |=> !reg_rdata[1])
    else $error("check fail flag not cleared by read");
  a_loaded_sets: assert property (subcode_loaded_event ##2 rd54 |=> reg_rdata[0])
    else $error("subcode loaded flag not set");
  a_rdata_holds: assert property (!reg_read |=> $stable(reg_rdata))
    else $error("read data moved without a read");
  // ==========================================================
  // Professional bit paths
  a_rx_pro_load: assert property (
    rxw0 ##1 !rxw0 |=> rx_professional_use_bit == $past(rx_cs_data[0], 2))
    else $error("received professional bit wrong");
  a_tx_pro_auto: assert property (
    $past(cs_autobuffer) && $past(cs_autobuffer, 2) |-> tx_professional_use_bit == rx_professional_use_bit)
    else $error("autobuffered professional bit wrong");
endmodule // spdif_regs_checker

bind spdif_status_user_buffers spdif_regs_checker spdif_regs_checker_i (.core_clk, .reset, .reg_read,
  .reg_addr, .reg_rdata, .cs_autobuffer, .compressed_cd_detect, .nonaudio_frame_detect, .subframe_a_detect,
  .subframe_b_detect, .subcode_check_fail_event, .subcode_loaded_event, .rx_cs_write, .rx_cs_index,
  .rx_cs_data, .tx_professional_use_bit, .rx_professional_use_bit);

// *** spdif_host_model.sv ***
// Purpose: Host controller model driving the decoded register port
// Assumes: Strobes taken on the rising edge, read data valid the edge after
// Notes:   Drives at falling edges; one idle cycle between transfers
`timescale 1ns/1ps
module control_host
  import spdif_regs_pkg::*;
(
  input  wire logic   core_clk,
  output logic         reg_write,
  output logic         reg_read,
  output reg_addr_type reg_addr,
  output byte_type     reg_wdata,
  input  wire byte_type reg_rdata
);
  initial begin
    {reg_write, reg_read, reg_addr, reg_wdata} = 17'h00000;
  end
  // ==========================================================
  // Transfer; released lines show the inverse so stale values never pass
  task automatic xfer(input logic wr_en, input reg_addr_type a, input byte_type d, output byte_type q);
    @(negedge core_clk);
    {reg_write, reg_read, reg_addr, reg_wdata} = {wr_en, !wr_en, a, d};
    @(negedge core_clk);
    q = reg_rdata;
    {reg_write, reg_read, reg_addr, reg_wdata} = {2'b00, ~a, ~d};
  endtask
endmodule // control_host

// *** spdif_status_user_buffers_tb_top.sv ***
// Purpose: Self-checking bench for the status and user-bit register group
// Assumes: control_host model on the register port
// Notes:   Random data from a fixed seed
`timescale 1ns/1ps
module spdif_status_user_buffers_tb_top;
  import spdif_regs_pkg::*;
  logic core_clk, reset, reg_write, reg_read, cs_autobuffer, user_autobuffer, rx_cs_write, rx_user_write;
  logic compressed_cd_detect, nonaudio_frame_detect, subframe_a_detect, subframe_b_detect;
  logic subcode_check_fail_event, subcode_loaded_event, tx_professional_use_bit, rx_professional_use_bit;
  logic [4:0]   rx_cs_index, tx_cs_index;
  reg_addr_type reg_addr;
  byte_type     reg_wdata, reg_rdata, rx_cs_data, rx_user_index, rx_user_data, tx_cs_data;
  byte_type     tx_user_index, tx_user_data, got, p, d1, d2, d3;
  byte_type     rx_cs[24];
  byte_type     tx_cs[24];
  reg_addr_type ra[8] = '{7'h1F, 7'h20, 7'h38, 7'h50, 7'h52, 7'h53, 7'h54, 7'h60};
  int           n_errors, checks_done;

  spdif_status_user_buffers spdif_status_user_buffers_i (.*);
  control_host control_host_i (.*);

  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  // ==========================================================
  // Helpers
  task automatic chk(input string name, input byte_type exp, input byte_type seen);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  function automatic byte_type status_exp(input logic fail, input logic loaded);
    return {6'h00, fail, loaded};
  endfunction
  task automatic wr(input reg_addr_type a, input byte_type v);
    control_host_i.xfer(1'b1, a, v, got);
  endtask
  task automatic rd(input reg_addr_type a, input byte_type exp, input string name);
    control_host_i.xfer(1'b0, a, 8'h00, got);
    chk(name, exp, got);
  endtask
  task automatic cs_load(input int i, input byte_type v);
    @(negedge core_clk);
    {rx_cs_write, rx_cs_index, rx_cs_data} = {1'b1, 5'(i), v};
    @(negedge core_clk);
    {rx_cs_write, rx_cs_data} = {1'b0, ~v};
  endtask
  task automatic fetch(input int ci, input byte_type ui);
    @(negedge core_clk);
    {tx_cs_index, tx_user_index} = {5'(ci), ui};
    @(negedge core_clk);
  endtask
  task automatic give_verdict;
    $display("Mismatches %0d, checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    #100000;
    n_errors++;
    give_verdict();
  end
  // ==========================================================
  // Main sequence
  initial begin
    {n_errors, checks_done} = 64'h0;
    {reset, cs_autobuffer, user_autobuffer, rx_cs_write, rx_user_write} = 5'h10;
    {compressed_cd_detect, nonaudio_frame_detect, subframe_a_detect, subframe_b_detect} = 4'h0;
    {subcode_check_fail_event, subcode_loaded_event, rx_cs_index, tx_cs_index} = 12'h000;
    {rx_cs_data, rx_user_index, rx_user_data, tx_user_index} = 32'h0000_0000;
    void'($urandom(32'h0261));
    repeat (16) @(negedge core_clk);
    reset = 1'b0;
    foreach (ra[k]) rd(ra[k], 8'h00, "reset value");
    for (int v = 0; v < 16; v++) begin
      @(negedge core_clk);
      {compressed_cd_detect, nonaudio_frame_detect, subframe_a_detect, subframe_b_detect} = v[3:0];
      wr(7'h1F, 8'hFF);
      rd(7'h1F, {4'h0, v[3:0]}, "nonaudio flags");
    end
    // Host writes to the receive buffer must lose while not autobuffering
    for (int i = 0; i < 24; i++) begin
      rx_cs[i] = byte_type'($urandom);
      cs_load(i, rx_cs[i]);
      wr(7'(32 + i), ~rx_cs[i]);
      tx_cs[i] = byte_type'($urandom);
      if (i == 0) tx_cs[0][0] = ~rx_cs[0][0];
      wr(7'(56 + i), tx_cs[i]);
    end
    for (int i = 0; i < 24; i++) begin
      rd(7'(32 + i), rx_cs[i], "rx status byte");
      fetch(i, 8'h00);
      chk("tx status fetch", tx_cs[i], tx_cs_data);
    end
    chk("rx pro bit", {7'h00, rx_cs[0][0]}, {7'h00, rx_professional_use_bit});
    chk("tx pro bit", {7'h00, tx_cs[0][0]}, {7'h00, tx_professional_use_bit});
    cs_autobuffer = 1'b1;
    for (int i = 0; i < 24; i++) begin
      wr(7'(56 + i), ~tx_cs[i]);
      rx_cs[i] = byte_type'($urandom);
      wr(7'(32 + i), rx_cs[i]);
      rd(7'(32 + i), rx_cs[i], "rx status host write");
      fetch(i, 8'h00);
      chk("autobuffered fetch", rx_cs[i], tx_cs_data);
    end
    chk("auto pro bit", {7'h00, rx_cs[0][0]}, {7'h00, tx_professional_use_bit});
    cs_autobuffer = 1'b0;
    for (int i = 0; i < 24; i++) begin
      rd(7'(56 + i), tx_cs[i], "tx status kept");
    end
    // User bits; pointer corners first
    for (int k = 0; k < 6; k++) begin
      p = (k == 0) ? 8'h00 : (k == 1) ? 8'hFF : byte_type'($urandom);
      {d1, d2, d3} = 24'($urandom);
      @(negedge core_clk);
      {rx_user_write, rx_user_index, rx_user_data} = {1'b1, p, d1};
      @(negedge core_clk);
      rx_user_write = 1'b0;
      wr(7'h50, p);
      rd(7'h50, p, "rx pointer");
      wr(7'h51, ~d1);
      rd(7'h51, d1, "rx user byte");
      wr(7'h52, p);
      rd(7'h52, p, "tx pointer");
      wr(7'h53, d2);
      rd(7'h53, 8'h00, "tx user read");
      fetch(0, p);
      chk("tx user fetch", d2, tx_user_data);
      user_autobuffer = 1'b1;
      wr(7'h51, d3);
      wr(7'h53, ~d2);
      rd(7'h51, d3, "rx user host write");
      fetch(0, p);
      chk("auto user fetch", d3, tx_user_data);
      user_autobuffer = 1'b0;
      fetch(0, p);
      chk("tx user kept", d2, tx_user_data);
    end
    // Subcode flags
    @(negedge core_clk);
    subcode_check_fail_event = 1'b1;
    @(negedge core_clk);
    subcode_check_fail_event = 1'b0;
    rd(7'h54, status_exp(1'b1, 1'b0), "check fail set");
    wr(7'h54, 8'hFF);
    rd(7'h54, 8'h00, "check fail cleared");
    @(negedge core_clk);
    subcode_loaded_event = 1'b1;
    @(negedge core_clk);
    subcode_loaded_event = 1'b0;
    rd(7'h54, 8'h01, "loaded set");
    fork
      rd(7'h54, 8'h01, "read with fail");
      begin
        @(negedge core_clk);
        subcode_check_fail_event = 1'b1;
        @(negedge core_clk);
        subcode_check_fail_event = 1'b0;
      end
    join
    rd(7'h54, status_exp(1'b1, 1'b1), "fail wins over clear");
    rd(7'h54, status_exp(1'b0, 1'b1), "loaded sticky");
    // Mid-run reset must clear the receive pointer, receive status byte 0x20 and the sticky loaded flag
    wr(7'h50, 8'h5A);
    @(negedge core_clk);
    reset = 1'b1;
    repeat (2) @(negedge core_clk);
    reset = 1'b0;
    rd(7'h50, 8'h00, "pointer after reset");
    rd(7'h20, 8'h00, "status buffer after reset");
    rd(7'h54, status_exp(1'b0, 1'b0), "flags after reset");
    give_verdict();
  end
endmodule // spdif_status_user_buffers_tb_top
